// ==== rtl/ccis_pkg.sv ====
// package: constants for the paged control-port block
package ccis_pkg;
    // ----------------------------------------
    // bus address and registers
    // ----------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h18;
    localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
    localparam logic [6:0] PAGE_SELECT_OFS = 7'h00;
    localparam logic [6:0] SOFTWARE_RESET_OFS = 7'h01;
    localparam logic [6:0] BUS_ERROR_CTRL_OFS = 7'h6b;
    localparam int BUS_ERROR_STATUS_BIT = 0;
    localparam int BUS_ERROR_DISABLE_BIT = 2;
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [7:0] PAGE_ONE_VALUE = 8'h01;
    localparam logic [7:0] PAGE_ZERO_VALUE = 8'h00;
    localparam int REGS_PER_PAGE = 128;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLOCK_HZ = 50000000;
    localparam int RESET_PULSE_NS = 10;
    localparam int RESET_PULSE_CYCLES =
        ((RESET_PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000) < 1 ? 1 :
        ((RESET_PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000);
    // phase step of the master end: 2.5 us, scl half period is two steps, standard-mode safe
    localparam int SCL_HALF_NS = 2500;
    localparam int SCL_HALF_CYCLES = SCL_HALF_NS * (CLOCK_HZ / 1000000) / 1000;
    // bus stall that ends a glitched transfer: 1 ms
    localparam int STALL_US = 1000;
    localparam int STALL_CYCLES = STALL_US * (CLOCK_HZ / 1000000);
endpackage : ccis_pkg

// ==== rtl/ccis_bus_if.sv ====
// interface: open-drain two-wire bus plus the reset pin
interface ccis_bus_if;
    logic scl_o_master;
    logic scl_oe_master;
    logic sda_o_master;
    logic sda_oe_master;
    logic sda_o_slave;
    logic sda_oe_slave;
    logic reset_n;
    wire scl = scl_oe_master ? scl_o_master : 1'b1;
    wire sda = (sda_oe_master && !sda_o_master) || (sda_oe_slave && !sda_o_slave) ? 1'b0 : 1'b1;
    modport device (
        input scl, sda, reset_n,
        output sda_o_slave, sda_oe_slave
    );
    modport host (
        input scl, sda,
        output scl_o_master, scl_oe_master, sda_o_master, sda_oe_master, reset_n
    );
endinterface : ccis_bus_if

// ==== rtl/ccis_slave.sv ====
// module: paged register slave on the two-wire control bus
//
// Overview of operation
// R1 - host pulses reset pin low first
// R2 - software reset clears both pages
// R3 - two pages of 128 byte registers
// R4 - address zero selects page for others
// R5 - any reset returns to page zero
// R6 - 0x01 selects page one, 0x00 zero
// R7 - host reads page register back after change
// R8 - seven-bit addressing, standard and fast speed
// R9 - answers only address 0x18 plus general
// R10 - slave only, never drives clock
// R11 - sda only pulled low or released
// R12 - start and stop seen while scl high
// R13 - ninth clock carries acknowledge
// R14 - general call address acknowledged
// R15 - written bytes auto-increment register address
// R16 - acknowledged read returns next register
// R17 - bus-error detector ends glitched transfers
// R18 - detector status bit 0, disable bit 2
// R19 - first written byte is register address
// R20 - read uses address write then restart
module ccis_slave #(
    parameter int STALL_LIMIT = ccis_pkg::STALL_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // bus
    ccis_bus_if.device bus,
    // user side
    output logic [7:0] active_page,
    output logic bus_error_seen
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK} ccis_state_e;

    // ----------------------------------------
    // input sampling and edge detection
    // ----------------------------------------
    logic [1:0] scl_q, scl_d, sda_q, sda_d;
    logic rstn_q, rstn_d;
    logic scl_rise, scl_fall, start_seen, stop_seen;
    always_comb begin
        scl_d = {scl_q[0], bus.scl};
        sda_d = {sda_q[0], bus.sda};
        rstn_d = bus.reset_n;
        scl_rise = scl_q[0] && !scl_q[1];
        scl_fall = !scl_q[0] && scl_q[1];
        start_seen = scl_q[0] && scl_q[1] && sda_q[1] && !sda_q[0]; // [R12]
        stop_seen = scl_q[0] && scl_q[1] && !sda_q[1] && sda_q[0]; // [R12]
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            scl_q <= 2'b11;
            sda_q <= 2'b11;
            rstn_q <= 1'b1;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
            rstn_q <= rstn_d;
        end
    end

    // ----------------------------------------
    // register storage and transfer engine
    // ----------------------------------------
    logic [7:0] mem_q [2*ccis_pkg::REGS_PER_PAGE]; // [R3]
    logic [7:0] mem_d [2*ccis_pkg::REGS_PER_PAGE];
    ccis_state_e state_q, state_d;
    logic [7:0] shift_q, shift_d;
    logic [3:0] bit_q, bit_d;
    logic [6:0] reg_q, reg_d;
    logic have_reg_q, have_reg_d;
    logic reading_q, reading_d;
    logic ack_q, ack_d;
    logic page_q, page_d;
    logic drive_low_q, drive_low_d;
    logic err_q, err_d;
    logic [31:0] stall_q, stall_d;
    logic dev_reset, sw_reset, det_en;
    logic [7:0] read_byte;
    logic [7:0] rx_byte;

    always_comb begin
        det_en = !mem_q[ccis_pkg::BUS_ERROR_CTRL_OFS][ccis_pkg::BUS_ERROR_DISABLE_BIT];
        read_byte = (reg_q == ccis_pkg::PAGE_SELECT_OFS) ? {7'h00, page_q}
            : mem_q[{page_q, reg_q}];
        if (reg_q == ccis_pkg::BUS_ERROR_CTRL_OFS && !page_q) begin
            read_byte[ccis_pkg::BUS_ERROR_STATUS_BIT] = err_q; // [R18]
        end
        rx_byte = {shift_q[6:0], sda_q[1]};
    end

    always_comb begin
        mem_d = mem_q;
        state_d = state_q;
        shift_d = shift_q;
        bit_d = bit_q;
        reg_d = reg_q;
        have_reg_d = have_reg_q;
        reading_d = reading_q;
        ack_d = ack_q;
        page_d = page_q;
        drive_low_d = drive_low_q;
        err_d = err_q;
        sw_reset = 1'b0;
        stall_d = (state_q == ST_IDLE || scl_rise || scl_fall) ? 32'h0 : stall_q + 32'h1;
        if (start_seen) begin
            state_d = ST_ADDR;
            bit_d = 4'h0;
            drive_low_d = 1'b0;
        end else if (stop_seen) begin
            state_d = ST_IDLE;
            drive_low_d = 1'b0;
            have_reg_d = 1'b0;
        end else if (det_en && stall_q >= 32'(STALL_LIMIT)) begin
            state_d = ST_IDLE; // [R17]
            drive_low_d = 1'b0;
            err_d = 1'b1;
        end else begin
            case (state_q)
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise) begin
                        shift_d = rx_byte;
                        bit_d = bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        if (state_q == ST_ADDR) begin
                            ack_d = (shift_q[7:1] == ccis_pkg::SLAVE_ADDR) // [R9] [R8]
                                || (shift_q[7:1] == ccis_pkg::GENERAL_CALL_ADDR); // [R14]
                            reading_d = shift_q[0];
                            have_reg_d = 1'b0;
                        end else begin
                            ack_d = 1'b1;
                            if (!have_reg_q) begin
                                reg_d = shift_q[6:0]; // [R19]
                                have_reg_d = 1'b1;
                            end else begin
                                if (reg_q == ccis_pkg::PAGE_SELECT_OFS) begin
                                    if (shift_q == ccis_pkg::PAGE_ONE_VALUE) page_d = 1'b1; // [R6]
                                    if (shift_q == ccis_pkg::PAGE_ZERO_VALUE) page_d = 1'b0; // [R6]
                                end else if (reg_q == ccis_pkg::SOFTWARE_RESET_OFS && !page_q) begin
                                    sw_reset = 1'b1; // [R2]
                                end else begin
                                    mem_d[{page_q, reg_q}] = shift_q; // [R4]
                                end
                                reg_d = reg_q + 7'h1; // [R15]
                            end
                        end
                        drive_low_d = ack_d; // [R13] [R11]
                        state_d = ST_ACK;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        if (!ack_q) begin
                            drive_low_d = 1'b0;
                            state_d = ST_IDLE;
                        end else if (reading_q) begin
                            shift_d = read_byte;
                            drive_low_d = !read_byte[7];
                            state_d = ST_READ;
                        end else begin
                            drive_low_d = 1'b0;
                            state_d = ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        bit_d = bit_q + 4'h1;
                        shift_d = {shift_q[6:0], 1'b1};
                        if (bit_q == 4'h7) begin
                            drive_low_d = 1'b0;
                            reg_d = reg_q + 7'h1; // [R16]
                            state_d = ST_RACK;
                        end else begin
                            drive_low_d = !shift_q[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) ack_d = !sda_q[1];
                    if (scl_fall) begin
                        bit_d = 4'h0;
                        if (ack_q) begin
                            shift_d = read_byte; // [R16]
                            drive_low_d = !read_byte[7];
                            state_d = ST_READ;
                        end else begin
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: ;
            endcase
        end
        if (sw_reset) begin
            for (int i = 0; i < 2 * ccis_pkg::REGS_PER_PAGE; i++) begin
                mem_d[i] = ccis_pkg::REG_RESET_VALUE; // [R2]
            end
            page_d = 1'b0; // [R5]
            err_d = 1'b0;
        end
    end

    assign dev_reset = srst || !rstn_q;
    always_ff @(posedge clock) begin
        if (dev_reset) begin
            mem_q <= '{default: ccis_pkg::REG_RESET_VALUE};
            state_q <= ST_IDLE;
            shift_q <= 8'h00;
            bit_q <= 4'h0;
            reg_q <= 7'h00;
            have_reg_q <= 1'b0;
            reading_q <= 1'b0;
            ack_q <= 1'b0;
            page_q <= 1'b0; // [R5]
            drive_low_q <= 1'b0;
            err_q <= 1'b0;
            stall_q <= 32'h0;
        end else begin
            mem_q <= mem_d;
            state_q <= state_d;
            shift_q <= shift_d;
            bit_q <= bit_d;
            reg_q <= reg_d;
            have_reg_q <= have_reg_d;
            reading_q <= reading_d;
            ack_q <= ack_d;
            page_q <= page_d;
            drive_low_q <= drive_low_d;
            err_q <= err_d;
            stall_q <= stall_d;
        end
    end

    // ----------------------------------------
    // outputs: sda only low or released, scl never driven
    // ----------------------------------------
    assign bus.sda_o_slave = 1'b0; // [R11] [R10]
    assign bus.sda_oe_slave = drive_low_q;
    assign active_page = {7'h00, page_q};
    assign bus_error_seen = err_q;
endmodule : ccis_slave

// ==== rtl/ccis_master.sv ====
// module: host end issuing register reads and writes
module ccis_master #(
    parameter int HALF = ccis_pkg::SCL_HALF_CYCLES
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // bus
    ccis_bus_if.host bus,
    // request
    input wire logic req_valid,
    input wire logic req_read,
    input wire logic [6:0] req_dev,
    input wire logic [7:0] req_reg,
    input wire logic [7:0] req_data,
    // answer
    output logic busy,
    output logic done,
    output logic nack,
    output logic [7:0] rd_data
);
    typedef enum logic [2:0] {MS_RST, MS_IDLE, MS_START, MS_BIT, MS_STOP} ccis_mstate_e;
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    ccis_mstate_e st_q, st_d;
    logic [15:0] tick_q, tick_d;
    logic [1:0] ph_q, ph_d;
    logic [3:0] bit_q, bit_d;
    logic [1:0] byte_q, byte_d;
    logic [7:0] tx_q, tx_d, rx_q, rx_d;
    logic rd_q, rd_d, scl_q, scl_d, sdal_q, sdal_d, rst_q, rst_d, done_q, done_d, nack_q, nack_d;
    logic [6:0] dev_q, dev_d;
    logic [7:0] reg_q, reg_d, dat_q, dat_d;
    logic step;
    always_comb begin
        st_d = st_q; tick_d = tick_q + 16'h1; ph_d = ph_q; bit_d = bit_q; byte_d = byte_q;
        tx_d = tx_q; rx_d = rx_q; rd_d = rd_q; scl_d = scl_q; sdal_d = sdal_q;
        rst_d = rst_q; done_d = 1'b0; nack_d = nack_q; dev_d = dev_q; reg_d = reg_q; dat_d = dat_q;
        step = tick_q >= 16'(HALF);
        if (step) tick_d = 16'h0;
        case (st_q)
            MS_RST: if (tick_q >= 16'(ccis_pkg::RESET_PULSE_CYCLES)) begin // [R1]
                rst_d = 1'b0; st_d = MS_IDLE;
            end
            MS_IDLE: if (req_valid) begin
                dev_d = req_dev; reg_d = req_reg; dat_d = req_data; rd_d = req_read;
                byte_d = 2'd0; nack_d = 1'b0; tx_d = {req_dev, 1'b0};
                st_d = MS_START; ph_d = 2'd0; tick_d = 16'h0;
            end
            MS_START: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) begin scl_d = 1'b0; sdal_d = 1'b0; end
                if (ph_q == 2'd1) scl_d = 1'b1;
                if (ph_q == 2'd2) sdal_d = 1'b1;
                if (ph_q == 2'd3) begin scl_d = 1'b0; st_d = MS_BIT; bit_d = 4'h0; ph_d = 2'd0; end
            end
            MS_BIT: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) begin
                    // ack slot and read data left to the slave, last read byte nacked
                    sdal_d = (bit_q == 4'h8 || (byte_q == 2'd3 && rd_q)) ? 1'b0 : !tx_q[7]; // [R20]
                end
                if (ph_q == 2'd1) scl_d = 1'b1;
                if (ph_q == 2'd2) begin
                    if (bit_q == 4'h8 && byte_q != 2'd3 && bus.sda) nack_d = 1'b1; // [R13]
                    if (bit_q != 4'h8) begin rx_d = {rx_q[6:0], bus.sda}; tx_d = {tx_q[6:0], 1'b0}; end
                end
                if (ph_q == 2'd3) begin
                    scl_d = 1'b0; ph_d = 2'd0; bit_d = bit_q + 4'h1;
                    if (bit_q == 4'h8) begin
                        bit_d = 4'h0; byte_d = byte_q + 2'd1;
                        if (nack_q) st_d = MS_STOP;
                        else if (byte_q == 2'd0) tx_d = reg_q; // [R19]
                        else if (byte_q == 2'd1 && !rd_q) tx_d = dat_q;
                        else if (byte_q == 2'd1) begin // [R20]
                            st_d = MS_START; tx_d = {dev_q, 1'b1}; byte_d = 2'd2;
                        end else if (byte_q == 2'd2 && rd_q) begin byte_d = 2'd3; sdal_d = 1'b0; end
                        else st_d = MS_STOP;
                    end
                end
            end
            MS_STOP: if (step) begin
                ph_d = ph_q + 2'd1;
                if (ph_q == 2'd0) sdal_d = 1'b1;
                if (ph_q == 2'd1) scl_d = 1'b1;
                if (ph_q == 2'd2) begin sdal_d = 1'b0; st_d = MS_IDLE; done_d = 1'b1; end
            end
            default: st_d = MS_IDLE;
        endcase
    end
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= MS_RST; tick_q <= 16'h0; ph_q <= 2'd0; bit_q <= 4'h0; byte_q <= 2'd0;
            tx_q <= 8'h00; rx_q <= 8'h00; rd_q <= 1'b0; scl_q <= 1'b1; sdal_q <= 1'b0;
            rst_q <= 1'b1; done_q <= 1'b0; nack_q <= 1'b0;
            dev_q <= 7'h00; reg_q <= 8'h00; dat_q <= 8'h00;
        end else begin
            st_q <= st_d; tick_q <= tick_d; ph_q <= ph_d; bit_q <= bit_d; byte_q <= byte_d;
            tx_q <= tx_d; rx_q <= rx_d; rd_q <= rd_d; scl_q <= scl_d; sdal_q <= sdal_d;
            rst_q <= rst_d; done_q <= done_d; nack_q <= nack_d;
            dev_q <= dev_d; reg_q <= reg_d; dat_q <= dat_d;
        end
    end
    assign bus.scl_o_master = 1'b0;
    assign bus.scl_oe_master = !scl_q;
    assign bus.sda_o_master = 1'b0;
    assign bus.sda_oe_master = sdal_q;
    assign bus.reset_n = !rst_q; // [R1]
    assign busy = st_q != MS_IDLE;
    assign done = done_q;
    assign nack = nack_q;
    assign rd_data = rx_q;
endmodule : ccis_master

// ==== tb/ccis_properties.sv ====
// checker: bus-level properties of the paged control port
module ccis_properties (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // bus lines
    input wire logic scl_o_master,
    input wire logic scl_oe_master,
    input wire logic sda_o_master,
    input wire logic sda_oe_master,
    input wire logic sda_o_slave,
    input wire logic sda_oe_slave,
    input wire logic reset_n,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // bit counter and address capture
    // ----------------------------------------
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_q;
    logic [3:0] bit_d;
    logic [7:0] sh_q;
    logic [7:0] sh_d;
    always_comb begin
        bit_d = bit_q;
        sh_d = sh_q;
        if (scl && scl_q && sda_q && !sda) begin
            bit_d = 4'h0;
        end else if (scl && !scl_q && bit_q != 4'hf) begin
            bit_d = bit_q + 4'h1;
            sh_d = {sh_q[6:0], sda};
        end
    end
    always_ff @(posedge clock) begin
        scl_q <= scl;
        sda_q <= sda;
        bit_q <= srst ? 4'hf : bit_d;
        sh_q <= sh_d;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_slave_low; sda_oe_slave |-> !sda_o_slave; endproperty
    a_slave_low: assert property (p_slave_low) else $error("slave drives high");
    property p_master_low; !(scl_oe_master && scl_o_master) && !(sda_oe_master && sda_o_master);
    endproperty
    a_master_low: assert property (p_master_low) else $error("master drives high");
    property p_slave_scl_low; $changed(sda_oe_slave) |-> !scl; endproperty
    a_slave_scl_low: assert property (p_slave_scl_low) else $error("sda moved, scl high");
    property p_no_slave_start; $fell(sda) && scl |-> !sda_oe_slave; endproperty
    a_no_slave_start: assert property (p_no_slave_start) else $error("slave start");
    property p_ack_hold; $rose(scl) && sda_oe_slave |-> sda_oe_slave [*3]; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("slave bit not held");
    property p_addr_quiet; scl && scl_q && bit_q >= 4'h1 && bit_q <= 4'h8 |-> !sda_oe_slave;
    endproperty
    a_addr_quiet: assert property (p_addr_quiet) else $error("slave in address");
    property p_ack_addr; scl && !scl_q && bit_q == 4'h8 |-> sda_oe_slave ==
        (sh_q[7:1] == ccis_pkg::SLAVE_ADDR || sh_q[7:1] == ccis_pkg::GENERAL_CALL_ADDR);
    endproperty
    a_ack_addr: assert property (p_ack_addr) else $error("wrong address ack");
    property p_stop_release; scl && $rose(sda) |=> !sda_oe_slave [*8]; endproperty
    a_stop_release: assert property (p_stop_release) else $error("drive after stop");
    property p_start_hold; scl && $fell(sda) |-> scl [*3]; endproperty
    a_start_hold: assert property (p_start_hold) else $error("start too short");
    property p_reset_release; !reset_n |-> ##2 !sda_oe_slave; endproperty
    a_reset_release: assert property (p_reset_release) else $error("drive in reset");
endmodule // ccis_properties

// ==== tb/testbench.sv ====
// testbench: master and slave ends facing each other
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clock, srst, req_valid, req_read, busy, done, nack, err, err2, bb_ack;
    logic [6:0] req_dev;
    logic [7:0] req_reg, req_data, rd_data, page, page2, bb_rx;
    int failures, samples_checked;
    ccis_bus_if bus ();
    ccis_bus_if bus2 ();
    ccis_slave #(.STALL_LIMIT(200)) u_ccis_slave (.clock(clock), .srst(srst),
        .bus(bus.device), .active_page(page), .bus_error_seen(err));
    ccis_slave #(.STALL_LIMIT(200)) u_ccis_slave_b (.clock(clock), .srst(srst),
        .bus(bus2.device), .active_page(page2), .bus_error_seen(err2));
    ccis_master #(.HALF(4)) u_ccis_master (.clock(clock), .srst(srst), .bus(bus.host),
        .req_valid(req_valid), .req_read(req_read), .req_dev(req_dev), .req_reg(req_reg),
        .req_data(req_data), .busy(busy), .done(done), .nack(nack), .rd_data(rd_data));
    ccis_properties u_ccis_properties (.clock(clock), .srst(srst),
        .scl_o_master(bus.scl_o_master), .scl_oe_master(bus.scl_oe_master),
        .sda_o_master(bus.sda_o_master), .sda_oe_master(bus.sda_oe_master),
        .sda_o_slave(bus.sda_o_slave), .sda_oe_slave(bus.sda_oe_slave),
        .reset_n(bus.reset_n), .scl(bus.scl), .sda(bus.sda));
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] rg,
        input logic [7:0] dt);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (busy !== 1'b0 && n < 2000);
        req_valid = 1'b1;
        req_read = rd;
        req_dev = dev;
        req_reg = rg;
        req_data = dt;
        @(posedge clock);
        #1;
        req_valid = 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (done !== 1'b1 && n < 5000);
        chk({7'h0, done}, 8'h01, "done");
    endtask
    task automatic wr(input logic [7:0] rg, input logic [7:0] dt);
        xfer(1'b0, ccis_pkg::SLAVE_ADDR, rg, dt);
        chk({7'h0, nack}, 8'h00, "write nack");
    endtask
    task automatic rdc(input logic [7:0] rg, input logic [7:0] exp);
        xfer(1'b1, ccis_pkg::SLAVE_ADDR, rg, 8'h00);
        chk({7'h0, nack}, 8'h00, "read nack");
        chk(rd_data, exp, "read data");
    endtask
    // second bus driven bit by bit for bursts
    task automatic bb_wait;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task automatic bb_clk(input logic b, output logic r);
        bus2.sda_oe_master = !b;
        bb_wait();
        bus2.scl_oe_master = 1'b0;
        bb_wait();
        r = bus2.sda;
        bus2.scl_oe_master = 1'b1;
        bb_wait();
    endtask
    task automatic bb_start;
        bus2.sda_oe_master = 1'b0;
        bb_wait();
        bus2.scl_oe_master = 1'b0;
        bb_wait();
        bus2.sda_oe_master = 1'b1;
        bb_wait();
        bus2.scl_oe_master = 1'b1;
        bb_wait();
    endtask
    task automatic bb_stop;
        bus2.sda_oe_master = 1'b1;
        bb_wait();
        bus2.scl_oe_master = 1'b0;
        bb_wait();
        bus2.sda_oe_master = 1'b0;
        bb_wait();
    endtask
    task automatic bb_byte(input logic [7:0] tx, input logic last, output logic [7:0] rx,
        output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bb_clk(tx[i], r);
            rx[i] = r;
        end
        bb_clk(last, r);
        ack = !r;
    endtask
    task automatic results;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // watchdog and sequence
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clock);
        failures++;
        $display("CHECK FAILED at %0t: watchdog", $time);
        results();
    end
    initial begin
        srst = 1'b1;
        req_valid = 1'b0;
        req_read = 1'b0;
        req_dev = 7'h00;
        req_reg = 8'h00;
        req_data = 8'h00;
        failures = 0;
        samples_checked = 0;
        bus2.scl_o_master = 1'b0;
        bus2.scl_oe_master = 1'b0;
        bus2.sda_o_master = 1'b0;
        bus2.sda_oe_master = 1'b0;
        bus2.reset_n = 1'b0;
        repeat (5) @(posedge clock);
        #1;
        srst = 1'b0;
        bus2.reset_n = 1'b1;
        rdc(8'h00, 8'h00);
        chk(page, 8'h00, "page");
        rdc(8'h6b, 8'h00);
        wr(8'h10, 8'ha5);
        wr(8'h7f, 8'h77);
        wr(8'h00, 8'h01);
        rdc(8'h00, 8'h01);
        chk(page, 8'h01, "page");
        rdc(8'h10, 8'h00);
        wr(8'h10, 8'h3c);
        wr(8'h01, 8'h66);
        rdc(8'h01, 8'h66);
        wr(8'h00, 8'h02);
        rdc(8'h00, 8'h01);
        wr(8'h00, 8'h00);
        rdc(8'h10, 8'ha5);
        rdc(8'h7f, 8'h77);
        xfer(1'b0, ccis_pkg::GENERAL_CALL_ADDR, 8'h20, 8'h5a);
        chk({7'h0, nack}, 8'h00, "general call");
        rdc(8'h20, 8'h5a);
        xfer(1'b0, 7'h19, 8'h20, 8'h11);
        chk({7'h0, nack}, 8'h01, "foreign address");
        rdc(8'h20, 8'h5a);
        wr(8'h6b, 8'h04);
        rdc(8'h6b, 8'h04);
        wr(8'h01, 8'h01);
        rdc(8'h10, 8'h00);
        rdc(8'h6b, 8'h00);
        wr(8'h00, 8'h01);
        rdc(8'h10, 8'h00);
        rdc(8'h01, 8'h00);
        srst = 1'b1;
        repeat (5) @(posedge clock);
        #1;
        srst = 1'b0;
        rdc(8'h00, 8'h00);
        bb_start();
        bb_byte({ccis_pkg::SLAVE_ADDR, 1'b0}, 1'b1, bb_rx, bb_ack);
        chk({7'h0, bb_ack}, 8'h01, "burst address ack");
        bb_byte(8'h30, 1'b1, bb_rx, bb_ack);
        bb_byte(8'h11, 1'b1, bb_rx, bb_ack);
        bb_byte(8'h22, 1'b1, bb_rx, bb_ack);
        chk({7'h0, bb_ack}, 8'h01, "burst data ack");
        bb_stop();
        bb_start();
        bb_byte({ccis_pkg::SLAVE_ADDR, 1'b0}, 1'b1, bb_rx, bb_ack);
        bb_byte(8'h30, 1'b1, bb_rx, bb_ack);
        bb_start();
        bb_byte({ccis_pkg::SLAVE_ADDR, 1'b1}, 1'b1, bb_rx, bb_ack);
        bb_byte(8'hff, 1'b0, bb_rx, bb_ack);
        chk(bb_rx, 8'h11, "burst read first");
        bb_byte(8'hff, 1'b1, bb_rx, bb_ack);
        chk(bb_rx, 8'h22, "burst read next");
        bb_stop();
        bus2.sda_oe_master = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        bus2.scl_oe_master = 1'b1;
        repeat (260) @(posedge clock);
        #1;
        chk({7'h0, err2}, 8'h01, "detector fired");
        chk({7'h0, err}, 8'h00, "no stall seen");
        chk({7'h0, bus2.sda}, 8'h00, "sda held by host");
        bus2.sda_oe_master = 1'b0;
        repeat (4) @(posedge clock);
        #1;
        chk({7'h0, bus2.sda}, 8'h01, "sda released");
        results();
    end
endmodule // testbench
